// [sar_params.svh]
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_CLK_PS       5000
`define SAR_BUSY_DLY_NS  50
`define SAR_BUSY_FALL_NS 65
`define SAR_DATA_MAX_NS  8000
`define SAR_BUSY_DLY_CYC ((`SAR_BUSY_DLY_NS * 1000 + `SAR_CLK_PS - 1) / `SAR_CLK_PS)
`define SAR_BUSY_FALL_CYC ((`SAR_BUSY_FALL_NS * 1000) / `SAR_CLK_PS)
`define SAR_DATA_MAX_CYC ((`SAR_DATA_MAX_NS * 1000) / `SAR_CLK_PS)
`define SAR_RESULT_RST   16'h0000
`define SAR_SIGN_BIT     15
`define SAR_FIFO_DEPTH   4
`endif

// [sar_pkg.sv]
package sar_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_SETTLE
   } conv_state_t;
endpackage

// [result_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   fifo_no_over_a: assert property (@(posedge clk_sys) disable iff (srst)
      cnt_q <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// [conv_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_timer #(
   parameter int W = 12
) (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic             expired
);
   logic [W-1:0] cnt_q;
   logic         run_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         run_q <= 1'b1;
      end else if (run_q && cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Stays high until the next load, so a late consumer cannot miss it
   assign expired = run_q && (cnt_q == '0) && !load;
endmodule
`default_nettype wire

// [sar_adc_convert_read_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_adc_convert_read_port #(
   parameter int DATA_MAX_CYC = `SAR_DATA_MAX_CYC,
   parameter int FIFO_DEPTH   = `SAR_FIFO_DEPTH
) (
   input  wire logic          clk_sys,
   input  wire logic          srst,
   input  wire logic          cs_n,
   input  wire logic          rc_n,
   input  wire logic          byte_sel,
   output logic               busy_n,
   output sar_pkg::word_t     result_bus,
   output logic               result_bus_oe_n,
   output logic               hold,
   output logic               conv_start,
   input  wire logic          core_valid,
   output logic               core_ready,
   input  wire sar_pkg::word_t core_data,
   output logic               result_stale,
   output logic               result_late
);
   import sar_pkg::*;

   localparam int TW = 13;

   conv_state_t state_q;
   conv_state_t state_d;
   word_t       result_q;
   word_t       fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;
   logic        start;
   logic        settle_done;
   logic        watchdog_exp;
   logic        reacq_q;
   logic        stale_q;
   logic        late_q;
   logic        drive;
   word_t       bus_q;
   logic        oe_n_q;
   logic [TW:0] conv_cyc_q;
   logic [TW:0] settle_cyc_q;

   result_fifo #(
      .W (16),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .in_valid  (core_valid),
      .in_ready  (core_ready),
      .in_data   (core_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Starts are level triggered: both controls low and no conversion running
   assign start = (state_q == ST_IDLE) && !cs_n && !rc_n;

   // One word per conversion; spare words wait for later conversions
   assign fifo_pop = (state_q == ST_CONV) && fifo_valid;

   // Settle delay after the result update, started by either way out of conversion
   conv_timer #(
      .W (TW)
   ) u_settle (
      .clk_sys (clk_sys),
      .srst    (srst),
      .load    (fifo_pop || (state_q == ST_CONV && watchdog_exp)),
      .count   (TW'(`SAR_BUSY_DLY_CYC - 1)),
      .expired (settle_done)
   );

   // Bound on the core: if no word arrives in time the old word is kept
   conv_timer #(
      .W (TW)
   ) u_watchdog (
      .clk_sys (clk_sys),
      .srst    (srst),
      .load    (start),
      .count   (TW'(DATA_MAX_CYC - 1)),
      .expired (watchdog_exp)
   );

   // Settle keeps busy low after the update so data is steady when busy rises
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            if (fifo_pop || watchdog_exp) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (settle_done) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Busy low one cycle after the start, well inside the allowed delay
   assign busy_n = (state_q == ST_IDLE);

   // Sample/hold sits in hold for the whole conversion, tracks otherwise
   assign hold = !busy_n;

   assign conv_start = start;

   // Long bounds are checked on these counts instead of long delay ranges
   always_ff @(posedge clk_sys) begin
      if (srst || state_q != ST_CONV) begin
         conv_cyc_q <= '0;
      end else begin
         conv_cyc_q <= conv_cyc_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || state_q != ST_SETTLE) begin
         settle_cyc_q <= '0;
      end else begin
         settle_cyc_q <= settle_cyc_q + 1'b1;
      end
   end

   // Core delivers offset binary; flipping the top bit gives two's complement
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         result_q <= `SAR_RESULT_RST;
      end else if (fifo_pop) begin
         result_q <= fifo_data ^ (word_t'(1) << `SAR_SIGN_BIT);
      end
   end

   // Restart straight out of a conversion has had no acquisition time
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reacq_q <= 1'b0;
      end else begin
         reacq_q <= (state_q == ST_SETTLE) && settle_done;
      end
   end

   // Stale mark belongs to the conversion it was taken with
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stale_q <= 1'b0;
      end else if (start) begin
         stale_q <= reacq_q;
      end
   end

   // A late core leaves the previous word in place; the flag tells the host
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         late_q <= 1'b0;
      end else if (start) begin
         late_q <= 1'b0;
      end else if (state_q == ST_CONV && watchdog_exp && !fifo_valid) begin
         late_q <= 1'b1;
      end
   end

   assign result_stale = stale_q && busy_n;
   assign result_late  = late_q;

   // Bus drives only for chip select low and read/convert high
   assign drive = !cs_n && rc_n;

   // Registered so the enable never glitches while the controls settle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= !drive;
      end
   end

   // Lanes swap with the half select so either byte sits on either group
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus_q <= '0;
      end else if (byte_sel) begin
         bus_q <= {result_q[7:0], result_q[15:8]};
      end else begin
         bus_q <= result_q;
      end
   end

   assign result_bus      = bus_q;
   assign result_bus_oe_n = oe_n_q;

   // Pin contract checks; long timing bounds use the helper counts above
   busy_fall_a: assert property (@(posedge clk_sys) disable iff (srst)
      start |=> !busy_n) else $error("busy did not fall after start");

   busy_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
      $fell(busy_n) |-> !busy_n [*2])
      else $error("busy low for less than two cycles");

   ignore_busy_a: assert property (@(posedge clk_sys) disable iff (srst)
      !busy_n |-> !start) else $error("start accepted while busy");

   hold_start_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!cs_n && !rc_n && busy_n) |=> hold) else $error("no hold");

   bus_enable_a: assert property (@(posedge clk_sys) disable iff (srst)
      ##1 (result_bus_oe_n == !$past(!cs_n && rc_n)))
      else $error("bus enable wrong");

   cs_high_a: assert property (@(posedge clk_sys) disable iff (srst)
      cs_n |=> result_bus_oe_n) else $error("bus driven with cs high");

   twos_comp_a: assert property (@(posedge clk_sys) disable iff (srst)
      fifo_pop |=> result_q == {!$past(fifo_data[15]), $past(fifo_data[14:0])})
      else $error("result not two's complement");

   byte_lane_a: assert property (@(posedge clk_sys) disable iff (srst)
      byte_sel |=> result_bus == {$past(result_q[7:0]), $past(result_q[15:8])})
      else $error("byte lanes wrong");

   word_lane_a: assert property (@(posedge clk_sys) disable iff (srst)
      !byte_sel |=> result_bus == $past(result_q)) else $error("word lanes wrong");

   settle_gap_a: assert property (@(posedge clk_sys) disable iff (srst)
      fifo_pop |=> !busy_n [*8] ##1 !busy_n [*2]) else $error("busy rose too early");

   prev_result_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!busy_n && !fifo_pop) |=> $stable(result_q))
      else $error("result changed mid conversion");

   data_bound_a: assert property (@(posedge clk_sys) disable iff (srst)
      (state_q == ST_CONV) |-> conv_cyc_q < (TW+1)'(DATA_MAX_CYC))
      else $error("result not valid within bound");

   settle_len_a: assert property (@(posedge clk_sys) disable iff (srst)
      (state_q == ST_SETTLE && settle_done) |-> settle_cyc_q == (TW+1)'(`SAR_BUSY_DLY_CYC - 1))
      else $error("settle time wrong");

   rise_settle_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(busy_n) |-> $past(state_q) == ST_SETTLE) else $error("busy rose outside settle");

   one_pop_a: assert property (@(posedge clk_sys) disable iff (srst)
      fifo_pop |=> !fifo_pop) else $error("two words taken in one conversion");

   fifo_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
      busy_n |-> !fifo_pop) else $error("word taken while idle");

   start_release_a: assert property (@(posedge clk_sys) disable iff (srst)
      conv_start |=> result_bus_oe_n) else $error("bus driven after start");

   tied_cs_a: assert property (@(posedge clk_sys) disable iff (srst)
      (!cs_n && rc_n) |=> !result_bus_oe_n) else $error("bus not driven for read");

   cs_nop_a: assert property (@(posedge clk_sys) disable iff (srst)
      cs_n |-> !conv_start) else $error("start with chip select high");

   stale_mark_a: assert property (@(posedge clk_sys) disable iff (srst)
      conv_start |=> stale_q == $past(reacq_q)) else $error("stale mark wrong");

   stale_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
      result_stale |-> busy_n) else $error("stale shown during conversion");

   late_mark_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(result_late) |-> state_q == ST_SETTLE) else $error("late flag outside settle");

   late_bound_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(result_late) |-> $past(conv_cyc_q) == (TW+1)'(DATA_MAX_CYC - 1))
      else $error("late flag before bound");

   late_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
      conv_start |=> !result_late) else $error("late flag not cleared");

   track_end_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(busy_n) |-> !hold) else $error("still holding after conversion");

   conv_cycle_c: cover property (@(posedge clk_sys) disable iff (srst)
      (state_q == ST_SETTLE) ##1 $rose(busy_n));
   restart_c: cover property (@(posedge clk_sys) disable iff (srst)
      start && reacq_q);
   byte_read_c: cover property (@(posedge clk_sys) disable iff (srst)
      !result_bus_oe_n && byte_sel ##1 !result_bus_oe_n && !byte_sel);
   late_end_c: cover property (@(posedge clk_sys) disable iff (srst)
      state_q == ST_CONV && watchdog_exp && !fifo_valid);
   ignored_req_c: cover property (@(posedge clk_sys) disable iff (srst)
      !busy_n && !cs_n && !rc_n);
endmodule
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic           clk_sys,
   input  wire sar_pkg::word_t result_bus,
   input  wire logic           result_bus_oe_n,
   output var  logic           cs_n,
   output var  logic           rc_n,
   output var  logic           byte_sel
);
   import sar_pkg::*;
   initial begin
      cs_n = 1'b1;
      rc_n = 1'b1;
      byte_sel = 1'b0;
   end
   // Chip select leads, so the read/convert edge is the one that starts
   task automatic convert(input int lo, input bit keep, input logic cs_lvl);
      @(posedge clk_sys) cs_n <= cs_lvl;
      repeat (2) @(posedge clk_sys);
      rc_n <= 1'b0;
      repeat (lo) @(posedge clk_sys);
      if (!keep) begin
         rc_n <= 1'b1;
         cs_n <= 1'b1;
      end
   endtask
   // A released bus reads inverted, so a missing enable never matches
   task automatic read(input logic sel, output word_t d);
      @(posedge clk_sys);
      cs_n <= 1'b0;
      rc_n <= 1'b1;
      byte_sel <= sel;
      repeat (2) @(posedge clk_sys);
      d = result_bus_oe_n ? ~result_bus : result_bus;
   endtask
   task automatic release_bus;
      @(posedge clk_sys);
      cs_n <= 1'b1;
      rc_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// [sar_adc_convert_read_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_adc_convert_read_port_tb_top;
   import sar_pkg::*;
   logic  clk_sys = 1'b0;
   logic  srst = 1'b1;
   logic  core_valid = 1'b0;
   word_t core_data = 16'h0000;
   logic  cs_n, rc_n, byte_sel, busy_n, result_bus_oe_n, hold, conv_start;
   logic  core_ready, result_stale, result_late;
   word_t result_bus, rd;
   int    n_mismatch = 0;
   int    check_count = 0;
   int    n_start = 0;

   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (conv_start === 1'b1) n_start <= n_start + 1;

   sar_adc_convert_read_port #(.DATA_MAX_CYC(40), .FIFO_DEPTH(4)) dut_u (
      .clk_sys, .srst, .cs_n, .rc_n, .byte_sel, .busy_n, .result_bus, .result_bus_oe_n,
      .hold, .conv_start, .core_valid, .core_ready, .core_data, .result_stale, .result_late);
   host_model host_u (.clk_sys, .result_bus, .result_bus_oe_n, .cs_n, .rc_n, .byte_sel);

   task automatic chk_bit(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input word_t e, input word_t g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic push(input word_t w);
      @(posedge clk_sys);
      core_valid <= 1'b1;
      core_data <= w;
      @(posedge clk_sys);
      core_valid <= 1'b0;
   endtask
   task automatic wait_idle(output int n);
      n = 0;
      while (busy_n !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      chk_bit("busy back in time", 1'b1, busy_n);
   endtask
   task automatic conv_once(input word_t w, input bit push_it, input word_t e);
      int n;
      int s0;
      s0 = n_start;
      host_u.convert(8, 1'b0, 1'b0);
      chk_bit("busy after start", 1'b0, busy_n);
      chk_bit("hold in conversion", 1'b1, hold);
      if (push_it) push(w);
      wait_idle(n);
      if (push_it) chk_bit("busy rise delay", 1'b1, n >= 12 && n <= 14);
      chk_bit("one start taken", 1'b1, n_start == s0 + 1);
      host_u.read(1'b0, rd);
      chk_word("word read", e, rd);
      host_u.read(1'b1, rd);
      chk_word("byte read", {e[7:0], e[15:8]}, rd);
      host_u.release_bus();
   endtask
   task automatic t_reset;
      @(posedge clk_sys);
      chk_bit("busy idle", 1'b1, busy_n);
      chk_bit("bus released", 1'b1, result_bus_oe_n);
      chk_bit("buffer ready", 1'b1, core_ready);
   endtask
   task automatic t_codes;
      word_t w[4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
      for (int i = 0; i < 4; i++) conv_once(w[i], 1'b1, w[i] ^ 16'h8000);
   endtask
   task automatic t_ignore;
      int n;
      int s0;
      s0 = n_start;
      host_u.read(1'b0, rd);
      host_u.convert(8, 1'b1, 1'b0);
      chk_bit("bus off at start", 1'b1, result_bus_oe_n);
      host_u.read(1'b0, rd);
      chk_word("read in conversion", 16'h8000, rd);
      host_u.convert(4, 1'b0, 1'b0);
      chk_bit("request ignored", 1'b1, n_start == s0 + 1);
      push(16'h1234);
      wait_idle(n);
      host_u.read(1'b0, rd);
      chk_word("new result", 16'h9234, rd);
      host_u.release_bus();
   endtask
   task automatic t_cs_high;
      int s0;
      s0 = n_start;
      host_u.convert(8, 1'b0, 1'b1);
      chk_bit("no start", 1'b1, n_start == s0);
      chk_bit("still idle", 1'b1, busy_n);
      chk_bit("bus stays off", 1'b1, result_bus_oe_n);
   endtask
   // Words wait in the buffer until conversions take them, oldest first
   task automatic t_fifo;
      for (int i = 0; i < 4; i++) push(16'h8001 + 16'(i));
      @(posedge clk_sys);
      chk_bit("buffer full", 1'b0, core_ready);
      for (int i = 0; i < 4; i++) conv_once(16'h0000, 1'b0, 16'h0001 + 16'(i));
      chk_bit("buffer drained", 1'b1, core_ready);
   endtask
   task automatic t_restart;
      int n;
      int s0;
      s0 = n_start;
      host_u.convert(8, 1'b1, 1'b0);
      push(16'h8000);
      wait_idle(n);
      host_u.release_bus();
      @(posedge clk_sys);
      chk_bit("restart busy", 1'b0, busy_n);
      wait_idle(n);
      chk_bit("stale flag", 1'b1, result_stale);
      chk_bit("late flag", 1'b1, result_late);
      chk_bit("two starts", 1'b1, n_start == s0 + 2);
   endtask
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_codes();
      t_ignore();
      t_cs_high();
      t_fifo();
      t_restart();
      give_verdict();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #25000;
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
